// ==== wic_pkg.sv ====
// Shared types and constants for the wake and interrupt control block
package wic_pkg;

    // Instruction codes the CPU core presents on the command port
    typedef enum logic [3:0] {
        op_none,
        op_halt,
        op_stop,
        op_port_change_arm,
        op_halt_enable,
        op_irq_enable,
        op_stop_enable,
        op_request_clear,
        op_counter_start,
        op_status2_read,
        op_status3_read,
        op_status3x_read,
        op_status4_read
    } wic_op_e;

    typedef enum logic [1:0] {
        mode_run,
        mode_halt,
        mode_stop,
        mode_wake
    } wic_mode_e;

    typedef struct packed {
        wic_op_e op;
        logic [7:0] operand;
    } wic_cmd_s;

    // One-cycle events from neighbouring blocks, all on clk
    typedef struct packed {
        logic timer_one_uf;
        logic prediv_ovf;
        logic timer_two_uf;
        logic counter_finish;
        logic counter_ovf;
        logic port_c_change;
        logic port_d_change;
    } wic_src_s;

    localparam int NUM_REQ = 7;
    localparam int SYNC_STAGES = 3;
    localparam int PORT_WIDTH = 4;

    // Halt request indices
    localparam int REQ_PORT = 0;
    localparam int REQ_TIMER_ONE = 1;
    localparam int REQ_EXT_PIN = 2;
    localparam int REQ_PREDIV = 3;
    localparam int REQ_TIMER_TWO = 4;
    localparam int REQ_KEYS = 5;
    localparam int REQ_COUNTER = 6;

    // Operand bit positions
    localparam int ARM_PORT_C_BIT = 4;
    localparam int ARM_PORT_D_BIT = 3;
    localparam int STOP_EN_KEYS_BIT = 7;
    localparam int STOP_EN_EXT_BIT = 5;
    localparam int STOP_EN_PORTS_BIT = 4;

    // Status register 4 layout
    localparam int STATUS_FOUR_FLAGS_OVF_BIT = 2;
    localparam int STATUS_FOUR_FLAGS_WDT_BIT = 1;
    localparam int STATUS_FOUR_FLAGS_CLK_BIT = 0;

    // Reset values
    localparam logic [1:0] PORT_CHANGE_EN_RST = 2'h0;
    localparam logic [6:1] HALT_EN_RST = 6'h00;
    localparam logic [6:0] IRQ_EN_RST = 7'h00;
    localparam logic [2:0] STOP_EN_RST = 3'h0;

endpackage

// ==== wic_sync.sv ====
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ns
module wic_sync #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);
    import wic_pkg::*;

    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;

    if (WIDTH < 1) begin : g_chk
        $error("wic_sync needs WIDTH of at least 1");
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= '0;
            s2 <= '0;
            s3 <= '0;
        end else if (ce) begin
            meta <= d;
            s2 <= meta;
            s3 <= s2;
        end
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                q[i] <= 1'b0;
            end else if (ce && (s2[i] == s3[i])) begin
                q[i] <= s3[i];
            end
        end
    end
endmodule

// ==== wic_flag_bank.sv ====
// Bank of sticky flags where a set in the same cycle beats a clear
`timescale 1ns/1ns
module wic_flag_bank #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    output logic [WIDTH-1:0] q
);
    import wic_pkg::*;

    if (WIDTH < 1) begin : g_chk
        $error("wic_flag_bank needs WIDTH of at least 1");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_flag
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                q[i] <= 1'b0;
            end else if (ce) begin
                if (set[i]) begin
                    q[i] <= 1'b1;
                end else if (clr[i]) begin
                    q[i] <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== wic_top.sv ====
// Halt and stop release and interrupt enable control
//
// Overview of operation
// - Counter overflow sets flag; counter start clears it
// - Status 4 read gives overflow, watchdog, clock flags
// - Port C high in stop wakes if enabled
// - Port D high in stop wakes if enabled
// - Key latches high in stop wake if enabled
// - External pin change in stop raises request two
// - Stop refused unless ports input and low
// - Port-change enables written only by arming op
// - Armed port change releases halt, sets start flag
// - Port wake enters halt, falls back without flag
// - Port start flags raise request zero, interrupt zero
// - Accepted port interrupt blocks more until rearmed
// - Six halt enables gate the wake sources
// - External pin wakes stop with both enables
// - Key latches wake stop with both enables
// - Seven interrupt enables gate matching halt requests
// - Acceptance clears that request and its enable
// - Three stop enables written by stop-enable op
// - Request-clear operand bit n clears request n
// - Halt-enable operand bit n sets enable n
// - Operand bits: ports C/D 4/3, stops 7/5/4
// - Halt ignored while a release is pending
// - Stop with pending release enters halt instead
// - Arming op clears both port start flags
`timescale 1ns/1ns
module wic_top (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ce,
    input wic_pkg::wic_cmd_s cmd,
    input wic_pkg::wic_src_s src,
    input wire logic irq_ack,
    input wire logic [3:0] port_c_pins,
    input wire logic [3:0] port_c_input_mode,
    input wire logic [3:0] port_d_pins,
    input wire logic [3:0] port_d_input_mode,
    input wire logic ext_wake_pin,
    input wire logic [3:0] key_inputs,
    input wire logic prediv_stage15,
    input wire logic watchdog_on_flag,
    input wire logic clock_select_flag,
    output logic irq_req,
    output logic [2:0] irq_num,
    output logic [3:0] read_data,
    output logic halt_mode,
    output logic stop_mode,
    output logic stop_wake_condition,
    output logic counter_overflow_flag
);
    import wic_pkg::*;

    localparam int PIN_BITS = 3 * PORT_WIDTH + 1;

    // Reset release path: asserts at once, releases on the clock
    logic rst_meta;
    logic rst_n;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else if (ce) begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Pin conditioning
    logic [PIN_BITS-1:0] pins_raw;
    logic [PIN_BITS-1:0] pins_sync;
    logic [PORT_WIDTH-1:0] port_c_sync;
    logic [PORT_WIDTH-1:0] port_d_sync;
    logic [PORT_WIDTH-1:0] key_sync;
    logic ext_sync;

    assign pins_raw = {ext_wake_pin, key_inputs, port_d_pins, port_c_pins};

    // One shared synchroniser keeps all wake pins aligned to the same cycle
    wic_sync #(
        .WIDTH(PIN_BITS)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .d(pins_raw),
        .q(pins_sync)
    );

    assign port_c_sync = pins_sync[PORT_WIDTH-1:0];
    assign port_d_sync = pins_sync[2*PORT_WIDTH-1:PORT_WIDTH];
    assign key_sync = pins_sync[3*PORT_WIDTH-1:2*PORT_WIDTH];
    assign ext_sync = pins_sync[3*PORT_WIDTH];

    logic port_c_level;
    logic port_d_level;
    logic key_level;
    logic port_c_level_q;
    logic port_d_level_q;
    logic ext_q;
    logic port_c_change;
    logic port_d_change;
    logic ext_change;

    // Only pins in input mode take part; the rest are masked off
    assign port_c_level = |(port_c_sync & port_c_input_mode);
    assign port_d_level = |(port_d_sync & port_d_input_mode);
    assign key_level = |key_sync;

    // Edge history resets low, matching the idle level of the pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_c_level_q <= 1'b0;
            port_d_level_q <= 1'b0;
            ext_q <= 1'b0;
        end else if (ce) begin
            port_c_level_q <= port_c_level;
            port_d_level_q <= port_d_level;
            ext_q <= ext_sync;
        end
    end

    assign port_c_change = port_c_level ^ port_c_level_q;
    assign port_d_change = port_d_level ^ port_d_level_q;
    assign ext_change = ext_sync ^ ext_q;

    // Mode and instruction decode
    wic_mode_e mode;
    wic_mode_e next_mode;
    logic cpu_running;
    logic do_halt;
    logic do_stop;
    logic do_arm;
    logic do_halt_en;
    logic do_irq_en;
    logic do_stop_en;
    logic do_clear;
    logic do_counter_start;

    // Instructions only execute while the core runs
    assign cpu_running = (mode == mode_run);
    assign do_halt = ce && cpu_running && (cmd.op == op_halt);
    assign do_stop = ce && cpu_running && (cmd.op == op_stop);
    assign do_arm = ce && cpu_running && (cmd.op == op_port_change_arm);
    assign do_halt_en = ce && cpu_running && (cmd.op == op_halt_enable);
    assign do_irq_en = ce && cpu_running && (cmd.op == op_irq_enable);
    assign do_stop_en = ce && cpu_running && (cmd.op == op_stop_enable);
    assign do_clear = ce && cpu_running && (cmd.op == op_request_clear);
    assign do_counter_start = ce && cpu_running && (cmd.op == op_counter_start);

    // Enable registers, all write-only from the core
    logic [1:0] port_change_enables;
    logic [NUM_REQ-1:1] halt_release_enables;
    logic [NUM_REQ-1:0] interrupt_enables;
    logic [2:0] stop_release_enables;
    logic port_c_change_enable;
    logic port_d_change_enable;
    logic stop_enable_port_c;
    logic stop_enable_port_d;
    logic stop_enable_ext_pin;
    logic stop_enable_keys;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_change_enables <= PORT_CHANGE_EN_RST;
        end else if (do_arm) begin
            port_change_enables <= {cmd.operand[ARM_PORT_C_BIT], cmd.operand[ARM_PORT_D_BIT]};
        end
    end

    assign port_c_change_enable = port_change_enables[1];
    assign port_d_change_enable = port_change_enables[0];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            halt_release_enables <= HALT_EN_RST;
        end else if (do_halt_en) begin
            halt_release_enables <= cmd.operand[NUM_REQ-1:1];
        end
    end

    logic irq_take;
    logic [NUM_REQ-1:0] irq_pending;

    // A fresh write wins over an acceptance in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            interrupt_enables <= IRQ_EN_RST;
        end else if (do_irq_en) begin
            interrupt_enables <= cmd.operand[NUM_REQ-1:0];
        end else if (irq_take) begin
            interrupt_enables[irq_num] <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_release_enables <= STOP_EN_RST;
        end else if (do_stop_en) begin
            stop_release_enables <= {cmd.operand[STOP_EN_KEYS_BIT],
                cmd.operand[STOP_EN_EXT_BIT], cmd.operand[STOP_EN_PORTS_BIT]};
        end
    end

    // One enable serves both ports
    assign stop_enable_keys = stop_release_enables[2];
    assign stop_enable_ext_pin = stop_release_enables[1];
    assign stop_enable_port_c = stop_release_enables[0];
    assign stop_enable_port_d = stop_release_enables[0];

    // Port start flags and the port interrupt lockout
    logic [1:0] start_set;
    logic [1:0] start_clr;
    logic [1:0] port_start_flags;
    logic port_c_start_flag;
    logic port_d_start_flag;
    logic port_irq_blocked;

    assign start_set = {port_c_change && port_c_change_enable,
        port_d_change && port_d_change_enable};
    assign start_clr = {2{do_arm}};

    wic_flag_bank #(
        .WIDTH(2)
    ) u_start_flags (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .set(start_set),
        .clr(start_clr),
        .q(port_start_flags)
    );

    assign port_c_start_flag = port_start_flags[1];
    assign port_d_start_flag = port_start_flags[0];

    // Once port interrupt is taken, port changes stop requesting it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_irq_blocked <= 1'b0;
        end else if (ce) begin
            if (irq_take && (irq_num == 3'(REQ_PORT))) begin
                port_irq_blocked <= 1'b1;
            end else if (do_arm) begin
                port_irq_blocked <= 1'b0;
            end
        end
    end

    // Halt requests
    logic [NUM_REQ-1:0] req_set;
    logic [NUM_REQ-1:0] req_clr;
    logic [NUM_REQ-1:0] halt_request;
    logic halt_request_port;
    logic halt_request_ext_pin;

    always_comb begin
        req_set = '0;
        req_set[REQ_PORT] = (|start_set) && !port_irq_blocked;
        req_set[REQ_TIMER_ONE] = src.timer_one_uf;
        req_set[REQ_EXT_PIN] = ext_change;
        req_set[REQ_PREDIV] = src.prediv_ovf;
        req_set[REQ_TIMER_TWO] = src.timer_two_uf;
        req_set[REQ_KEYS] = key_level;
        req_set[REQ_COUNTER] = src.counter_finish;
    end

    always_comb begin
        req_clr = '0;
        if (do_clear) begin
            req_clr = cmd.operand[NUM_REQ-1:0];
        end
        if (irq_take) begin
            req_clr[irq_num] = 1'b1;
        end
    end

    // A new event beats a clear in the same cycle
    wic_flag_bank #(
        .WIDTH(NUM_REQ)
    ) u_halt_requests (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .set(req_set),
        .clr(req_clr),
        .q(halt_request)
    );

    assign halt_request_port = halt_request[REQ_PORT];
    assign halt_request_ext_pin = halt_request[REQ_EXT_PIN];

    // Interrupts: lowest index wins
    assign irq_pending = halt_request & interrupt_enables;
    assign irq_req = |irq_pending;
    assign irq_take = ce && irq_ack && irq_req;

    always_comb begin
        irq_num = '0;
        for (int i = NUM_REQ - 1; i >= 0; i--) begin
            if (irq_pending[i]) begin
                irq_num = 3'(i);
            end
        end
    end

    // Release conditions
    logic [NUM_REQ-1:1] start_cond;
    logic halt_release_pending;
    logic in_stop;
    logic port_c_stop_request;
    logic port_d_stop_request;
    logic key_stop_request;
    logic stop_wake_set;
    logic stop_release;
    logic stop_release_hold;
    logic stop_release_pending;
    logic ports_ready;

    assign start_cond = halt_request[NUM_REQ-1:1] & halt_release_enables;
    assign halt_release_pending = (|port_start_flags) || (|start_cond) || irq_req;

    assign in_stop = (mode == mode_stop);
    assign port_c_stop_request = in_stop && port_c_level;
    assign port_d_stop_request = in_stop && port_d_level;
    assign key_stop_request = in_stop && key_level;

    assign stop_wake_set = (stop_enable_port_c && port_c_stop_request)
        || (stop_enable_port_d && port_d_stop_request)
        || (stop_enable_keys && key_stop_request)
        || (stop_enable_ext_pin && in_stop && ext_change);

    // Leaving stop needs the halt side enabled too, else the core would sleep on
    assign stop_release = (stop_enable_port_c && port_c_change_enable && port_c_stop_request)
        || (stop_enable_port_d && port_d_change_enable && port_d_stop_request)
        || (stop_enable_keys && halt_release_enables[REQ_KEYS] && key_stop_request)
        || (stop_enable_ext_pin && halt_release_enables[REQ_EXT_PIN] && in_stop
            && ext_change);

    assign stop_release_hold = (stop_enable_port_c && port_c_change_enable && port_c_level)
        || (stop_enable_port_d && port_d_change_enable && port_d_level)
        || (stop_enable_keys && halt_release_enables[REQ_KEYS] && key_level);

    assign stop_release_pending = (stop_enable_keys && key_level)
        || (stop_enable_ext_pin && halt_request_ext_pin);

    // Every port pin must be an input and low before entering stop
    assign ports_ready = (&port_c_input_mode) && (&port_d_input_mode)
        && !(|port_c_sync) && !(|port_d_sync);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_wake_condition <= 1'b0;
        end else if (ce) begin
            if (stop_wake_set) begin
                stop_wake_condition <= 1'b1;
            end else if (do_stop) begin
                stop_wake_condition <= 1'b0;
            end
        end
    end

    // Mode machine
    always_comb begin
        next_mode = mode;
        case (mode)
            mode_run: begin
                if (do_stop && ports_ready) begin
                    if (stop_release_pending) begin
                        next_mode = mode_halt;
                    end else begin
                        next_mode = mode_stop;
                    end
                end else if (do_halt && !halt_release_pending) begin
                    next_mode = mode_halt;
                end
            end
            mode_halt: begin
                if (halt_release_pending) begin
                    next_mode = mode_run;
                end
            end
            mode_stop: begin
                if (stop_release) begin
                    next_mode = mode_wake;
                end
            end
            mode_wake: begin
                // A short pulse that never set a flag drops back to stop
                if (halt_release_pending) begin
                    next_mode = mode_run;
                end else if (!stop_release_hold) begin
                    next_mode = mode_stop;
                end
            end
            default: begin
                next_mode = mode_run;
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= mode_run;
        end else if (ce) begin
            mode <= next_mode;
        end
    end

    assign halt_mode = (mode == mode_halt) || (mode == mode_wake);
    assign stop_mode = in_stop;

    // Counter overflow flag: overflow beats a start in the same cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counter_overflow_flag <= 1'b0;
        end else if (ce) begin
            if (src.counter_ovf) begin
                counter_overflow_flag <= 1'b1;
            end else if (do_counter_start) begin
                counter_overflow_flag <= 1'b0;
            end
        end
    end

    // Status reads
    logic [3:0] status4_word;
    logic status2_any;

    always_comb begin
        status4_word = '0;
        status4_word[STATUS_FOUR_FLAGS_OVF_BIT] = counter_overflow_flag;
        status4_word[STATUS_FOUR_FLAGS_WDT_BIT] = watchdog_on_flag;
        status4_word[STATUS_FOUR_FLAGS_CLK_BIT] = clock_select_flag;
    end

    // Key wake is not one of the summary sources
    assign status2_any = start_cond[REQ_TIMER_ONE] || start_cond[REQ_EXT_PIN]
        || start_cond[REQ_PREDIV] || start_cond[REQ_TIMER_TWO] || start_cond[REQ_COUNTER];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            read_data <= '0;
        end else if (ce && cpu_running) begin
            case (cmd.op)
                op_status2_read: begin
                    read_data <= {port_d_start_flag, status2_any, port_c_start_flag, 1'b0};
                end
                op_status3_read: begin
                    read_data <= {start_cond[REQ_PREDIV], prediv_stage15,
                        start_cond[REQ_TIMER_ONE], start_cond[REQ_EXT_PIN]};
                end
                op_status3x_read: begin
                    read_data <= {start_cond[REQ_COUNTER], 1'b0,
                        start_cond[REQ_TIMER_TWO], start_cond[REQ_KEYS]};
                end
                op_status4_read: begin
                    read_data <= status4_word;
                end
                default: begin
                    read_data <= read_data;
                end
            endcase
        end
    end

    // Checks
    ovf_set_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && src.counter_ovf |=> counter_overflow_flag)
        else $error("overflow flag not set");

    ovf_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_counter_start && !src.counter_ovf |=> !counter_overflow_flag)
        else $error("overflow flag not cleared");

    irq_load_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_irq_en |=> interrupt_enables == $past(cmd.operand[NUM_REQ-1:0]))
        else $error("interrupt enables not loaded");

    ack_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        irq_take && !do_irq_en |=> !interrupt_enables[$past(irq_num)])
        else $error("accepted interrupt enable not cleared");

    halt_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_running && do_halt && halt_release_pending |=> !halt_mode)
        else $error("halt entered with release pending");

    stop_refuse_a: assert property (@(posedge clk) disable iff (!rst_n)
        cpu_running && do_stop && !ports_ready |=> !stop_mode)
        else $error("stop entered with ports not ready");

    stop_divert_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_stop && ports_ready && stop_release_pending |=> halt_mode && !stop_mode)
        else $error("stop entered with stop release pending");

    arm_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
        do_arm && !(|start_set) |=> !(|port_start_flags))
        else $error("arming did not clear port start flags");
endmodule

// ==== wic_cpu_model.sv ====
// CPU core model presenting flag-control instructions
`timescale 1ns/1ns
module wic_cpu_model (
    input wire logic clk,
    output wic_pkg::wic_cmd_s cmd
);
    import wic_pkg::*;
    initial cmd = '0;
    // Each instruction stands for one cycle, so it executes exactly once
    task automatic issue(input wic_op_e op, input logic [7:0] arg);
        @(negedge clk);
        cmd <= '{op, arg};
        @(negedge clk);
        cmd <= '{op_none, 8'h00};
    endtask
endmodule

// ==== tb_top.sv ====
// Self-checking testbench for the wake and interrupt control block
`timescale 1ns/1ns
module tb_top;
    import wic_pkg::*;
    logic clk = 0, nrst = 0, wdt = 0, cs = 0, ack = 0, ext = 0, pre = 0;
    logic [3:0] pc = 0, pd = 0, ky = 0;
    wic_cmd_s cmd;
    wic_src_s src = '0;
    logic irq, hm, sm, swc, ovf;
    logic [2:0] num;
    logic [3:0] rd;
    logic [31:0] lf = 32'hed04;
    logic [15:0] q[$];
    logic [15:0] nt;
    int n_errors = 0, check_count = 0, cyc = 0;
    event smp;
    always #25 clk = ~clk;
    wic_cpu_model cpu (.clk(clk), .cmd(cmd));
    wic_top dut (.clk(clk), .nrst(nrst), .ce(1'b1),
        .cmd(cmd), .src(src), .irq_ack(ack), .port_c_pins(pc), .port_c_input_mode(4'hf),
        .port_d_pins(pd), .port_d_input_mode(4'hf), .ext_wake_pin(ext), .key_inputs(ky),
        .prediv_stage15(pre), .watchdog_on_flag(wdt), .clock_select_flag(cs),
        .irq_req(irq), .irq_num(num), .read_data(rd), .halt_mode(hm), .stop_mode(sm),
        .stop_wake_condition(swc), .counter_overflow_flag(ovf));
    function automatic logic [31:0] nx(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    function automatic logic [7:0] view(input int k);
        case (k)
            0: return {7'h00, ovf};
            1: return {4'h0, rd};
            2: return {4'h0, irq, num};
            4: return {5'h00, hm, sm, swc};
            default: return {7'h00, irq};
        endcase
    endfunction
    task automatic check(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic note(input int k, input logic [7:0] e);
        q.push_back({8'(k), e});
        ->smp;
    endtask
    task automatic w(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic summarize;
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Drains every note, since two notes in one time step wake this only once
    always @(smp) begin
        while (q.size() > 0) begin
            nt = q.pop_front();
            check(view(nt[15:8]), nt[7:0]);
        end
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_errors++;
            summarize();
        end
    end
    // Port pins stay low so no port change can wake anything here
    initial begin
        w(10);
        nrst = 1;
        w(4);
        note(0, 8'h00);
        note(3, 8'h00);
        src.counter_ovf = 1;
        w(1);
        src.counter_ovf = 0;
        w(4);
        note(0, 8'h01);
        for (int i = 0; i < 4; i++) begin
            lf = nx(lf);
            wdt = lf[0];
            cs = lf[1];
            pre = lf[2];
            cpu.issue(op_status4_read, 8'h00);
            w(3);
            note(1, {5'h00, 1'b1, wdt, cs});
        end
        cpu.issue(op_counter_start, 8'h00);
        cpu.issue(op_none, 8'h00);
        w(4);
        note(0, 8'h00);
        cpu.issue(op_halt_enable, 8'h02);
        cpu.issue(op_irq_enable, 8'h02);
        cpu.issue(op_none, 8'h00);
        src.timer_one_uf = 1;
        w(1);
        src.timer_one_uf = 0;
        w(4);
        note(2, 8'h09);
        ack = 1;
        w(1);
        ack = 0;
        w(4);
        note(3, 8'h00);
        cpu.issue(op_request_clear, 8'h7f);
        cpu.issue(op_halt_enable, 8'h24);
        cpu.issue(op_port_change_arm, 8'h10);
        cpu.issue(op_stop_enable, 8'hb0);
        cpu.issue(op_stop, 8'h00);
        w(2);
        note(4, 8'h02);
        ext = 1;
        w(8);
        note(4, 8'h01);
        cpu.issue(op_status3_read, 8'h00);
        w(2);
        note(1, {5'h00, pre, 2'h1});
        summarize();
    end
endmodule
